/* File: hdl/fap_pkg.sv */
// Package for the flash access protection block: register offsets,
// address map, field layouts and the carrier and state types.
// Assumes a 24-bit CPU byte address and a 32-bit classic Wishbone bus.
package fap_pkg;

  // Register byte offsets on the Wishbone slave.
  localparam logic [5:0] OFS_WE_LO  = 6'h00;
  localparam logic [5:0] OFS_WE_HI  = 6'h04;
  localparam logic [5:0] OFS_WE_DAT = 6'h08;
  localparam logic [5:0] OFS_STAT   = 6'h0C;
  localparam logic [5:0] OFS_PROT   = 6'h10;
  localparam logic [5:0] OFS_PIB_A  = 6'h14;
  localparam logic [5:0] OFS_PIB_D  = 6'h18;
  localparam logic [5:0] OFS_DIB_A  = 6'h1C;
  localparam logic [5:0] OFS_DIB_D  = 6'h20;

  // CPU address map of the main blocks.
  localparam logic [23:0] MB0_END  = 24'h01FFFF;
  localparam logic [23:0] MB1_END  = 24'h03FFFF;
  localparam logic [23:0] MB2_BASE = 24'h0E0000;
  localparam logic [23:0] MB2_END  = 24'h0E1FFF;
  localparam logic [23:0] BOOT_MAX = 24'h001BFF;

  // Section and boot granules, as address bit positions.
  localparam int PROG_SEC_LSB = 13;
  localparam int DATA_SEC_LSB = 9;
  localparam int BOOT_LSB     = 10;

  // Information block layout and the enable bit guarding block 1.
  localparam logic [7:0] IB1_BASE  = 8'h80;
  localparam int         IB1_WE_BIT = 15;

  // Status register bit positions.
  localparam int STAT_ENV_LSB = 0;
  localparam int STAT_PBUSY   = 3;
  localparam int STAT_DBUSY   = 4;

  // Reset values.
  localparam logic [15:0] WE_RST = 16'h0000;
  localparam logic [15:0] PW_RST = 16'h0000;

  // Protection word as held in the special array.
  typedef struct packed {
    logic [6:0] spare;
    logic [2:0] boot_end_boundary;
    logic [2:0] global_read_lock_field;
    logic [2:0] global_write_lock_field;
  } fap_prot_word_type;

  // CPU flash access request.
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [23:0] adr;
  } fap_cpu_acc_type;

  // Main block hit flags.
  typedef struct packed {
    logic mb0;
    logic mb1;
    logic mb2;
  } fap_region_type;

  // Information block write request.
  typedef struct packed {
    logic        pgm;
    logic        dat;
    logic [15:0] data;
  } fap_ib_wr_type;

  // Whole state of the top module.
  typedef struct packed {
    logic [15:0]       we_lo;
    logic [15:0]       we_hi;
    logic [15:0]       we_dat;
    fap_prot_word_type pw;
    logic [2:0]        env;
    logic              cap;
    logic              pbusy;
    logic              dbusy;
    logic              ack;
    logic [31:0]       rdat;
    logic              go;
    logic              rej;
    logic [7:0]        pib_a;
    logic [7:0]        dib_a;
    fap_ib_wr_type     ibw;
  } fap_state_type;

endpackage : fap_pkg

/* File: hdl/fap_flash_protect.sv */
// Flash access protection: section enables, boot and global locks,
// main block decode, indirect block addressing and module status.
// Assumes the protection word and the environment pins are stable at
// reset release, and that flash busy flags come from the flash macros.
//
// Function
// - Boot area from zero to programmable end
// - CPU writes into boot area always rejected
// - Code area writable if enabled and unlocked
// - Sections: 8K program, 512 byte data
// - Three enable registers gate section writes
// - Reset clears every section enable bit
// - Set enable bit permits section writes
// - Majority-zero write lock blocks CPU writes
// - Lock fields come from unmapped protection word
// - Majority-zero read lock blocks external reads
// - CPU reads unaffected by read lock
// - Main blocks direct, information blocks indirect
// - Separate indirect registers per memory
// - Main block 0, 1 and 2 address ranges
// - Information block indirect address ranges
// - Status byte: reserved, busy, environment
// - Environment bits sampled at reset, held
// - Busy mirror copies program flash busy
// - Data busy mirror copies data flash busy
//
// The Wishbone interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module fap_flash_protect
  import fap_pkg::*;
(
  input  wire logic            ref_clk_i,
  input  wire logic            rst_n_i,
  input  wire logic            wb_cyc_i,
  input  wire logic            wb_stb_i,
  input  wire logic            wb_we_i,
  input  wire logic [5:0]      wb_adr_i,
  input  wire logic [3:0]      wb_sel_i,
  input  wire logic [31:0]     wb_dat_i,
  output logic      [31:0]     wb_dat_o,
  output logic                 wb_ack_o,
  input  wire logic [15:0]     prot_word_i,
  input  wire logic [2:0]      environment_select_pins_i,
  input  wire logic            pgm_flash_busy_i,
  input  wire logic            dat_flash_busy_i,
  input  wire fap_cpu_acc_type cpu_acc_i,
  output logic                 cpu_rd_ok_o,
  output fap_region_type       region_o,
  output logic                 flash_wr_go_o,
  output logic                 flash_wr_reject_o,
  input  wire logic            dbg_rd_req_i,
  output logic                 dbg_rd_grant_o,
  output logic      [7:0]      pgm_ib_addr_o,
  output logic      [7:0]      dat_ib_addr_o,
  input  wire logic [15:0]     pgm_ib_data_i,
  input  wire logic [15:0]     dat_ib_data_i,
  output fap_ib_wr_type        ib_wr_o
);

  fap_state_type s_q;
  fap_state_type s_d;

  logic           bus_req;
  logic           wlock;
  logic           rlock;
  logic           in_boot;
  logic           sec_en;
  logic           wr_ok;
  fap_region_type hit;

  // A lock is active when fewer than two of its three bits are set.
  function automatic logic maj_zero(input logic [2:0] f);
    maj_zero = !((f[0] & f[1]) | (f[0] & f[2]) | (f[1] & f[2]));
  endfunction : maj_zero

  // Byte-lane merge for the 16-bit registers.
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0]  sel);
    merge16 = old;
    if (sel[0]) begin
      merge16[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      merge16[15:8] = dat[15:8];
    end
  endfunction : merge16

  // Lock decode from the captured protection word; before capture the
  // word reads zero, so both locks start closed, which is the safe side.
  assign wlock = maj_zero(s_q.pw.global_write_lock_field);
  assign rlock = maj_zero(s_q.pw.global_read_lock_field);

  // Main block decode of the CPU address.
  always_comb begin
    hit.mb0 = cpu_acc_i.adr <= MB0_END;
    hit.mb1 = (cpu_acc_i.adr > MB0_END) &&
              (cpu_acc_i.adr <= MB1_END);
    hit.mb2 = (cpu_acc_i.adr >= MB2_BASE) &&
              (cpu_acc_i.adr <= MB2_END);
  end

  // Boot area runs from zero up to boundary times 1K minus one; the
  // 3-bit field tops out at the last byte below 7K.
  assign in_boot = hit.mb0 && (cpu_acc_i.adr[23:BOOT_LSB] <
                   {11'h000, s_q.pw.boot_end_boundary});

  // Section enable lookup: low register for block 0, high for block 1.
  always_comb begin
    sec_en = 1'b0;
    if (hit.mb0) begin
      sec_en = s_q.we_lo[cpu_acc_i.adr[PROG_SEC_LSB+3:PROG_SEC_LSB]];
    end else if (hit.mb1) begin
      sec_en = s_q.we_hi[cpu_acc_i.adr[PROG_SEC_LSB+3:PROG_SEC_LSB]];
    end else if (hit.mb2) begin
      sec_en = s_q.we_dat[cpu_acc_i.adr[DATA_SEC_LSB+3:DATA_SEC_LSB]];
    end
  end

  // Code or data area write allowed only with section enable and no
  // global lock; the boot area never.
  assign wr_ok = sec_en && !wlock && !in_boot;

  assign bus_req = wb_cyc_i && wb_stb_i && !s_q.ack;

  // Next state: capture, mirrors, bus slave and write checking.
  always_comb begin
    s_d       = s_q;
    s_d.ack   = 1'b0;
    s_d.go    = 1'b0;
    s_d.rej   = 1'b0;
    s_d.ibw   = '0;
    s_d.pbusy = pgm_flash_busy_i;
    s_d.dbusy = dat_flash_busy_i;
    // One capture in the first cycle after reset release.
    if (!s_q.cap) begin
      s_d.cap = 1'b1;
      s_d.pw  = fap_prot_word_type'(prot_word_i);
      s_d.env = environment_select_pins_i;
    end
    // Registers answer one cycle after the request; unmapped offsets
    // still acknowledge, read zero and ignore writes.
    if (bus_req) begin
      s_d.ack  = 1'b1;
      s_d.rdat = 32'h0000_0000;
      unique case (wb_adr_i)
        OFS_WE_LO: begin
          s_d.rdat = {16'h0000, s_q.we_lo};
          if (wb_we_i) begin
            s_d.we_lo = merge16(s_q.we_lo, wb_dat_i, wb_sel_i);
          end
        end
        OFS_WE_HI: begin
          s_d.rdat = {16'h0000, s_q.we_hi};
          if (wb_we_i) begin
            s_d.we_hi = merge16(s_q.we_hi, wb_dat_i, wb_sel_i);
          end
        end
        OFS_WE_DAT: begin
          s_d.rdat = {16'h0000, s_q.we_dat};
          if (wb_we_i) begin
            s_d.we_dat = merge16(s_q.we_dat, wb_dat_i, wb_sel_i);
          end
        end
        OFS_STAT: begin
          s_d.rdat = {27'h0000000, s_q.dbusy, s_q.pbusy, s_q.env};
        end
        OFS_PROT: begin
          s_d.rdat = {16'h0000, s_q.pw};
        end
        OFS_PIB_A: begin
          s_d.rdat = {24'h000000, s_q.pib_a};
          if (wb_we_i && wb_sel_i[0]) begin
            s_d.pib_a = wb_dat_i[7:0];
          end
        end
        OFS_PIB_D: begin
          s_d.rdat = {16'h0000, pgm_ib_data_i};
          // Block 0 (below the block 1 base) is never CPU-writable.
          if (wb_we_i && s_q.pib_a >= IB1_BASE && !wlock &&
              s_q.we_hi[IB1_WE_BIT]) begin
            s_d.ibw.pgm  = 1'b1;
            s_d.ibw.data = wb_dat_i[15:0];
          end
        end
        OFS_DIB_A: begin
          s_d.rdat = {24'h000000, s_q.dib_a};
          if (wb_we_i && wb_sel_i[0]) begin
            s_d.dib_a = {1'b0, wb_dat_i[6:0]};
          end
        end
        OFS_DIB_D: begin
          s_d.rdat = {16'h0000, dat_ib_data_i};
          if (wb_we_i && !wlock) begin
            s_d.ibw.dat  = 1'b1;
            s_d.ibw.data = wb_dat_i[15:0];
          end
        end
        default: begin
          s_d.rdat = 32'h0000_0000;
        end
      endcase
    end
    // A refused CPU write raises only the reject strobe, so the flash
    // sees no start and its contents stay as they were.
    if (cpu_acc_i.wr && (hit.mb0 || hit.mb1 || hit.mb2)) begin
      s_d.go  = wr_ok;
      s_d.rej = !wr_ok;
    end
  end

  // State register; reset closes every section enable.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q        <= '0;
      s_q.we_lo  <= WE_RST;
      s_q.we_hi  <= WE_RST;
      s_q.we_dat <= WE_RST;
      s_q.pw     <= fap_prot_word_type'(PW_RST);
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs. CPU reads of any main block pass whatever the read lock.
  assign wb_dat_o          = s_q.rdat;
  assign wb_ack_o          = s_q.ack;
  assign region_o          = hit;
  assign cpu_rd_ok_o       = cpu_acc_i.rd &&
                             (hit.mb0 || hit.mb1 || hit.mb2);
  assign dbg_rd_grant_o    = dbg_rd_req_i && !rlock;
  assign flash_wr_go_o     = s_q.go;
  assign flash_wr_reject_o = s_q.rej;
  assign pgm_ib_addr_o     = s_q.pib_a;
  assign dat_ib_addr_o     = s_q.dib_a;
  assign ib_wr_o           = s_q.ibw;

  // Checks of the protection and status behaviour.
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_boot_wr;
    cpu_acc_i.wr && in_boot;
  endsequence

  sequence s_refused;
    flash_wr_reject_o && !flash_wr_go_o;
  endsequence

  sequence s_code_wr_ok;
    cpu_acc_i.wr && hit.mb1 && sec_en && !wlock;
  endsequence

  property p_boot_refused;
    s_boot_wr |=> s_refused;
  endproperty
  a_boot_refused: assert property (p_boot_refused)
    else $error("boot area write was not refused");

  property p_lock_blocks;
    cpu_acc_i.wr && wlock |=> !flash_wr_go_o;
  endproperty
  a_lock_blocks: assert property (p_lock_blocks)
    else $error("write started under global write lock");

  property p_code_write;
    s_code_wr_ok |=> flash_wr_go_o && !flash_wr_reject_o;
  endproperty
  a_code_write: assert property (p_code_write)
    else $error("enabled unlocked write was not started");

  property p_reset_clear;
    !s_q.cap |-> (s_q.we_lo == 16'h0000) && (s_q.we_hi == 16'h0000)
                 && (s_q.we_dat == 16'h0000);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("section enables not clear after reset");

  property p_read_lock;
    dbg_rd_req_i && rlock |-> !dbg_rd_grant_o;
  endproperty
  a_read_lock: assert property (p_read_lock)
    else $error("external read granted under read lock");

  property p_cpu_read;
    cpu_acc_i.rd && hit.mb2 |-> cpu_rd_ok_o;
  endproperty
  a_cpu_read: assert property (p_cpu_read)
    else $error("cpu flash read was blocked");

  property p_env_hold;
    s_q.cap ##1 s_q.cap |-> $stable(s_q.env);
  endproperty
  a_env_hold: assert property (p_env_hold)
    else $error("sampled environment bits changed");

  property p_busy_mirror;
    pgm_flash_busy_i ##1 (wb_cyc_i && wb_stb_i && !wb_we_i &&
      wb_adr_i == OFS_STAT && !wb_ack_o) |=>
      wb_ack_o && wb_dat_o[STAT_PBUSY];
  endproperty
  a_busy_mirror: assert property (p_busy_mirror)
    else $error("program busy not mirrored in status");

  property p_stat_reserved;
    bus_req && wb_adr_i == OFS_STAT |=> wb_dat_o[31:5] == 27'h0000000;
  endproperty
  a_stat_reserved: assert property (p_stat_reserved)
    else $error("status reserved bits not zero");

  property p_ib0_protect;
    ib_wr_o.pgm |-> s_q.pib_a >= IB1_BASE;
  endproperty
  a_ib0_protect: assert property (p_ib0_protect)
    else $error("write issued into information block 0");

  property p_sec_closed;
    cpu_acc_i.wr && (hit.mb0 || hit.mb1 || hit.mb2) && !sec_en |=>
      s_refused;
  endproperty
  a_sec_closed: assert property (p_sec_closed)
    else $error("write to a closed section was not refused");

  property p_no_stray;
    !cpu_acc_i.wr |=> !flash_wr_go_o && !flash_wr_reject_o;
  endproperty
  a_no_stray: assert property (p_no_stray)
    else $error("write strobe raised without a cpu write");

  property p_data_busy;
    1'b1 |=> s_q.dbusy == $past(dat_flash_busy_i);
  endproperty
  a_data_busy: assert property (p_data_busy)
    else $error("data flash busy not mirrored");

  property p_ib_with_ack;
    ib_wr_o.pgm || ib_wr_o.dat |-> wb_ack_o;
  endproperty
  a_ib_with_ack: assert property (p_ib_with_ack)
    else $error("information block write without bus answer");

endmodule : fap_flash_protect

/* File: verif/fap_cpu_model.sv */
// CPU-side partner: turns bench requests into flash access cycles.
// Assumes requests change just after a rising edge of the clock.
`timescale 1ns/1ns
module fap_cpu_model
  import fap_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        rd_i,
  input  wire logic        wr_i,
  input  wire logic [23:0] adr_i,
  input  wire logic        busy_i,
  output fap_cpu_acc_type  acc_o
);
  // Idle address lines toggle, so a decode that ignores the strobes
  // cannot pass on a stale address.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_o <= '0;
    end else begin
      acc_o.rd  <= rd_i;
      acc_o.wr  <= wr_i && !busy_i;
      acc_o.adr <= (rd_i || wr_i) ? adr_i : ~acc_o.adr;
    end
  end
endmodule : fap_cpu_model

/* File: verif/test_fap_flash_protect.sv */
// Self-checking bench for the flash access protection block.
// Assumes one-cycle Wishbone answers and lock fields taken at reset.
`timescale 1ns/1ns
module test_fap_flash_protect
  import fap_pkg::*;
;
  logic            ref_clk_i, rst_n_i, wb_cyc_i, wb_stb_i, wb_we_i;
  logic            wb_ack_o, pb, db, c_rd, c_wr, lk, rl;
  logic            cpu_rd_ok_o, flash_wr_go_o, flash_wr_reject_o;
  logic            dbg_rd_req_i, dbg_rd_grant_o;
  logic [5:0]      wb_adr_i;
  logic [3:0]      wb_sel_i, sl;
  logic [31:0]     wb_dat_i, wb_dat_o, q;
  logic [15:0]     pw, pgm_ib_data_i, dat_ib_data_i, sd, r, v;
  logic [15:0]     m[3];
  logic [2:0]      env, e0, h;
  logic [7:0]      pgm_ib_addr_o, dat_ib_addr_o;
  logic [23:0]     c_adr, a;
  logic [23:0]     corn[6] = '{24'h020000, 24'h03FFFF, 24'h040000,
                               24'h0E0000, 24'h0E1FFF, 24'h0E2000};
  fap_cpu_acc_type cpu_acc_i;
  fap_region_type  region_o;
  fap_ib_wr_type   ib_wr_o, ibs;
  int              errors, n_tests;

  // Design under test and the CPU model driving its access port.
  fap_flash_protect u_dut (
    .ref_clk_i, .rst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .prot_word_i(pw),
    .environment_select_pins_i(env), .pgm_flash_busy_i(pb),
    .dat_flash_busy_i(db), .cpu_acc_i, .cpu_rd_ok_o, .region_o,
    .flash_wr_go_o, .flash_wr_reject_o, .dbg_rd_req_i, .dbg_rd_grant_o,
    .pgm_ib_addr_o, .dat_ib_addr_o, .pgm_ib_data_i, .dat_ib_data_i,
    .ib_wr_o);
  fap_cpu_model u_cpu (.clk_i(ref_clk_i), .rst_n_i, .rd_i(c_rd),
    .wr_i(c_wr), .adr_i(c_adr), .busy_i(pb | db), .acc_o(cpu_acc_i));

  // Free-running 25 MHz clock.
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  function automatic logic [15:0] rnd();
    sd = {sd[14:0], sd[15] ^ sd[13] ^ sd[12] ^ sd[10]};
    return sd;
  endfunction : rnd

  function automatic logic maj0(input logic [2:0] f);
    return (!f[0] && !f[1]) || (!f[0] && !f[2]) || (!f[1] && !f[2]);
  endfunction : maj0

  // Word-aligned address somewhere in one of the three main blocks.
  function automatic logic [23:0] rnd_adr();
    logic [15:0] s;
    s = rnd();
    if (s[1:0] == 2'h0) return {7'h00, rnd(), 1'b0};
    if (s[1:0] == 2'h1) return {7'h01, rnd(), 1'b0};
    return {11'h070, s[15:4], 1'b0};
  endfunction : rnd_adr

  // Expected {go, reject} for a CPU write, from the enables and locks.
  function automatic logic [1:0] exp_wr(input logic [23:0] ad);
    logic s;
    s = (ad <= 24'h01FFFF) ? m[0][ad[16:13]] :
        (ad <= 24'h03FFFF) ? m[1][ad[16:13]] : m[2][ad[12:9]];
    s = s && !lk && (ad >= {11'h000, pw[8:6], 10'h000});
    return {s, !s};
  endfunction : exp_wr

  task automatic chk_reg(input string n, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk_reg

  task automatic chk_flag(input string n, input logic [3:0] e, g);
    chk_reg(n, {28'h0, e}, {28'h0, g});
  endtask : chk_flag

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test

  // Classic single Wishbone cycle; read data and the block write pulse
  // are taken at the rising edge that samples ack high, and the request
  // is released at that same edge.
  task automatic wb(input logic w, input logic [5:0] ad, input logic [31:0] d);
    int k;
    @(posedge ref_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= ad;
    wb_sel_i <= sl;
    wb_dat_i <= d;
    k = 0;
    do begin
      @(posedge ref_clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    if (wb_ack_o !== 1'b1) begin
      errors++;
      $display("mismatch wb_ack_o expected 1 seen %b", wb_ack_o);
      end_of_test();
    end
    q   = wb_dat_o;
    ibs = ib_wr_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  // One CPU write through the model; a missing answer reads as 00.
  task automatic wr_chk(input logic [23:0] ad);
    int k;
    @(posedge ref_clk_i);
    c_wr  <= 1'b1;
    c_adr <= ad;
    @(posedge ref_clk_i);
    c_wr <= 1'b0;
    k = 0;
    do begin
      @(negedge ref_clk_i);
      k++;
    end while (!(flash_wr_go_o | flash_wr_reject_o) && k < 6);
    chk_flag("wr_result", {2'h0, exp_wr(ad)},
             {2'h0, flash_wr_go_o, flash_wr_reject_o});
  endtask : wr_chk

  // Eight passes, each behind a fresh reset, walk every write-lock code.
  initial begin
    {rst_n_i, wb_cyc_i, wb_stb_i, wb_we_i, pb, db, c_rd, c_wr} = '0;
    {dbg_rd_req_i, wb_adr_i, wb_dat_i, c_adr} = '0;
    wb_sel_i = 4'hF;
    sl = 4'hF;
    errors = 0;
    n_tests = 0;
    sd = 16'h2DD5;  // Seed 11733.
    for (int i = 0; i < 8; i++) begin
      // Later passes reset on a rising edge, like every other input.
      if (i > 0) begin
        @(posedge ref_clk_i);
      end
      r = rnd();
      rst_n_i <= 1'b0;
      pw <= {7'h00, r[2:0], r[5:3], 3'(i)};
      env <= r[8:6];
      pgm_ib_data_i <= rnd();
      dat_ib_data_i <= rnd();
      e0 = r[8:6];
      lk = maj0(3'(i));
      rl = maj0(r[5:3]);
      repeat (6) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      env <= ~r[8:6];
      pb <= r[9];
      db <= r[10];
      wb(1'b0, OFS_STAT, 32'h0);
      chk_reg("status", {27'h0, r[10:9], e0}, q);
      pb <= 1'b0;
      db <= 1'b0;
      for (int j = 0; j < 3; j++) begin
        wb(1'b0, 6'(4 * j), 32'h0);
        chk_reg("we_reset", 32'h0, q);
        m[j] = rnd() | 16'h0001;
        wb(1'b1, 6'(4 * j), {rnd(), m[j]});
        // A lane-1 write must leave the low byte untouched.
        v = rnd();
        sl = 4'h2;
        wb(1'b1, 6'(4 * j), {16'hFFFF, v});
        sl = 4'hF;
        m[j][15:8] = v[15:8];
        wb(1'b0, 6'(4 * j), 32'h0);
        chk_reg("we_readback", {16'h0, m[j]}, q);
      end
      for (int j = 0; j < 6; j++) begin
        a = rnd_adr();
        if (j == 0 || (j == 1 && pw[8:6] != 3'h0)) begin
          a = {11'h000, pw[8:6], 10'h000} - 24'(2 * j);
        end
        wr_chk(a);
      end
      for (int j = 0; j < 7; j++) begin
        a = (j < 6) ? corn[j] : rnd_adr();
        h = {a <= 24'h01FFFF, a >= 24'h020000 && a <= 24'h03FFFF,
             a >= 24'h0E0000 && a <= 24'h0E1FFF};
        @(posedge ref_clk_i);
        c_rd  <= 1'b1;
        c_adr <= a;
        @(posedge ref_clk_i);
        c_rd <= 1'b0;
        @(negedge ref_clk_i);
        chk_flag("decode", {h, |h}, {region_o, cpu_rd_ok_o});
      end
      @(posedge ref_clk_i);
      dbg_rd_req_i <= 1'b1;
      @(negedge ref_clk_i);
      chk_flag("dbg_grant", {3'h0, !rl}, {3'h0, dbg_rd_grant_o});
      @(posedge ref_clk_i);
      dbg_rd_req_i <= 1'b0;
      wb(1'b1, OFS_DIB_A, 32'h000000FF);
      chk_reg("dat_ib_addr", 32'h7F, {24'h0, dat_ib_addr_o});
      wb(1'b1, OFS_DIB_D, {16'h0, r});
      chk_flag("dat_ib_wr", {3'h0, !lk}, {2'h0, ibs.pgm, ibs.dat});
      chk_reg("dat_ib_data", {16'h0, lk ? 16'h0000 : r},
              {16'h0, ibs.data});
      for (int k = 0; k < 2; k++) begin
        wb(1'b1, OFS_PIB_A, k ? 32'hFE : 32'h10);
        chk_reg("pgm_ib_addr", k ? 32'hFE : 32'h10,
                {24'h0, pgm_ib_addr_o});
        wb(1'b1, OFS_PIB_D, {16'h0, r});
        chk_flag("pgm_ib_wr", {2'h0, k && m[1][15] && !lk, 1'b0},
                 {2'h0, ibs.pgm, ibs.dat});
        chk_reg("pgm_ib_data", {16'h0, (k && m[1][15] && !lk) ? r : 16'h0},
                {16'h0, ibs.data});
      end
      wb(1'b0, OFS_PIB_D, 32'h0);
      chk_reg("pgm_ib_rd", {16'h0, pgm_ib_data_i}, q);
      wb(1'b1, OFS_PROT, ~{16'h0, pw});
      wb(1'b0, OFS_PROT, 32'h0);
      chk_reg("prot_word", {16'h0, pw}, q);
      wb(1'b1, 6'h3C, 32'hFFFFFFFF);
      wb(1'b0, 6'h3C, 32'h0);
      chk_reg("unmapped", 32'h0, q);
      for (int j = 0; j < 3; j++) begin
        m[j] = 16'h0000;
        wb(1'b1, 6'(4 * j), 32'h0);
      end
      wr_chk(rnd_adr());
      $display("test %0d done", i);
    end
    end_of_test();
  end
endmodule : test_fap_flash_protect
